// *** hdl/gdsp_top.sv ***
// dual asynchronous serial port with once-per-second tick, apb register access
// Notes on behaviour
// - two independent full-duplex ports, primary and secondary, each with tx and rx
// - tx lines driven at logic level, true polarity, no inversion
// - primary in binary protocol defaults to 9600 baud, 8 bits, odd parity, 1 stop
// - ascii primary and secondary port default to 4800 baud, 8 bits, no parity, 1 stop
// - secondary port takes correction input and sends text sentence output
// - baud, data bits, parity and stop bits of each port are writable
// - port settings kept in storage that survives reset and power loss
// - binary protocol sends raw bytes; ascii and sentence output only printable text, CR and LF
// - serial ports answer right after reset, without waiting for a fix
// - satellite tracking is enabled from reset with no command
// - tick pulse ten microseconds wide, repeated every second
// - tick rising edge aligned to start of the utc second
// - tick marked accurate only while valid position fixes are reported
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module gdsp_top
    import gdsp_pkg::*;
#(
    parameter int unsigned SECOND_CYCLES = SECOND_CYC
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // serial pins, index 0 primary, 1 secondary
    input  wire logic [1:0]  serial_rx_in,
    output logic [1:0]       serial_tx_out,
    // navigation solution, same clock
    input  wire logic        nav_second_start_in,
    input  wire logic        nav_fix_valid_in,
    // timing and receiver control
    output logic             second_tick_pulse_out,
    output logic             tick_accurate_out,
    output logic             track_enable_out
);

    localparam int SEC_W = $clog2(SECOND_CYCLES + 1);

    function automatic logic is_text(input logic [7:0] b);
        is_text = (b >= CHAR_LO && b <= CHAR_HI) || b == CHAR_CR || b == CHAR_LF;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = a == ADDR_CTRL || a == ADDR_CFG0 || a == ADDR_CFG1 || a == ADDR_DATA0 ||
                 a == ADDR_DATA1 || a == ADDR_STAT || a == ADDR_NVCMD;
    endfunction

    logic [2:0]       ctrl;
    gdsp_cfg_t        cfg [2];
    logic             boot_pending;
    logic [7:0]       rx_byte [2];
    logic [4:0]       stat [2];
    logic             tick_aligned;
    logic [1:0]       wr_tx;
    logic [1:0]       tx_reject;
    logic [1:0]       rd_rx;
    logic [4:0]       w1c [2];
    logic             access_done;
    logic             wr_done;
    logic [31:0]      next_rdata;

    // configuration image without reset: models the erasable store that outlives power loss
    gdsp_cfg_t        nv_cfg [2];
    logic [2:0]       nv_ctrl;
    logic [15:0]      nv_marker;
    logic             nv_valid;

    assign nv_valid    = nv_marker == NV_MARKER;
    assign access_done = psel_in && penable_in && pready_out;
    assign wr_done     = access_done && pwrite_in;

    ////////////////////////////////////////////////////////////////////////////////
    // apb: one wait state, answer on the second access cycle

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !mapped(paddr_in);
            if (psel_in && penable_in && !pready_out) begin
                prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (paddr_in)
            ADDR_CTRL:  next_rdata = {29'h0, ctrl};
            ADDR_CFG0:  next_rdata = {12'h0, cfg[0]};
            ADDR_CFG1:  next_rdata = {12'h0, cfg[1]};
            ADDR_DATA0: next_rdata = {24'h0, rx_byte[0]};
            ADDR_DATA1: next_rdata = {24'h0, rx_byte[1]};
            ADDR_STAT:  next_rdata = {14'h0, tick_aligned, nav_fix_valid_in, 3'h0, stat[1], 3'h0, stat[0]};
            ADDR_NVCMD: next_rdata = {31'h0, nv_valid};
            default:    next_rdata = 32'h0000_0000;
        endcase
    end

    // strobes toward the port engines
    generate
        for (genvar p = 0; p < 2; p++) begin : g_strobe
            localparam logic [7:0] DATA_ADDR = (p == 0) ? ADDR_DATA0 : ADDR_DATA1;
            logic text_mode;
            assign text_mode = (p == 1) || ctrl[CTRL_PROTO_BIT];
            // text ports refuse non-printable bytes other than CR and LF; binary passes any byte
            assign tx_reject[p] = wr_done && paddr_in == DATA_ADDR &&
                                  (stat[p][ST_TX_BUSY] || (text_mode && !is_text(pwdata_in[7:0])));
            assign wr_tx[p] = wr_done && paddr_in == DATA_ADDR && !tx_reject[p];
            assign rd_rx[p] = access_done && !pwrite_in && paddr_in == DATA_ADDR;
            assign w1c[p]   = (wr_done && paddr_in == ADDR_STAT) ?
                              (pwdata_in[p * ST_LANE +: 5] & ST_W1C_MASK) : 5'h00;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // control and port configuration

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl         <= CTRL_RESET;
            cfg[0]       <= CFG_BINARY;
            cfg[1]       <= CFG_TEXT;
            boot_pending <= 1'b1;
        end else begin
            boot_pending <= 1'b0;
            if ((boot_pending || (wr_done && paddr_in == ADDR_NVCMD && pwdata_in[NV_RESTORE_BIT])) &&
                nv_valid) begin
                ctrl   <= nv_ctrl;
                cfg[0] <= nv_cfg[0];
                cfg[1] <= nv_cfg[1];
            end else if (wr_done) begin
                case (paddr_in)
                    ADDR_CTRL: begin
                        ctrl <= pwdata_in[2:0];
                        // a protocol change on the primary port brings that protocol's framing
                        if (pwdata_in[CTRL_PROTO_BIT] != ctrl[CTRL_PROTO_BIT]) begin
                            cfg[0] <= pwdata_in[CTRL_PROTO_BIT] ? CFG_TEXT : CFG_BINARY;
                        end
                    end
                    ADDR_CFG0: cfg[0] <= gdsp_cfg_t'(pwdata_in[19:0]);
                    ADDR_CFG1: cfg[1] <= gdsp_cfg_t'(pwdata_in[19:0]);
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (wr_done && paddr_in == ADDR_NVCMD && pwdata_in[NV_SAVE_BIT]) begin
            nv_cfg[0] <= cfg[0];
            nv_cfg[1] <= cfg[1];
            nv_ctrl   <= ctrl;
            nv_marker <= NV_MARKER;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            track_enable_out <= 1'b1;
        end else begin
            track_enable_out <= ctrl[CTRL_TRACK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // port engines: ready from reset, no wait on the receiver's fix state

    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            gdsp_state_t tx_state;
            gdsp_state_t rx_state;
            logic [15:0] tx_cnt;
            logic [15:0] rx_cnt;
            logic [2:0]  tx_bit;
            logic [2:0]  rx_bit;
            logic [7:0]  tx_shift;
            logic [7:0]  rx_shift;
            logic        tx_pend;
            logic [7:0]  tx_hold;
            logic        tx_stop2;
            logic        rx_meta;
            logic        rx_pin;
            logic        rx_done;
            logic        rx_perr;
            logic        rx_ferr;
            logic [2:0]  last_bit;
            logic        tx_par;
            logic        rx_par;

            assign last_bit = cfg[p].eight_bits ? 3'h7 : 3'h6;
            assign tx_par   = (cfg[p].parity == GDSP_PAR_ODD) ? ~^(tx_hold & {cfg[p].eight_bits, 7'h7F})
                                                              : ^(tx_hold & {cfg[p].eight_bits, 7'h7F});
            assign rx_par   = (cfg[p].parity == GDSP_PAR_ODD) ? ~^rx_shift : ^rx_shift;

            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    rx_meta <= 1'b1;
                    rx_pin  <= 1'b1;
                end else begin
                    rx_meta <= serial_rx_in[p];
                    rx_pin  <= rx_meta;
                end
            end

            // transmitter; tx line idles high, plain polarity
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    tx_state         <= GDSP_S_IDLE;
                    tx_cnt           <= 16'h0000;
                    tx_bit           <= 3'h0;
                    tx_shift         <= 8'h00;
                    tx_pend          <= 1'b0;
                    tx_hold          <= 8'h00;
                    tx_stop2         <= 1'b0;
                    serial_tx_out[p] <= 1'b1;
                end else begin
                    if (wr_tx[p]) begin
                        tx_pend <= 1'b1;
                        tx_hold <= pwdata_in[7:0];
                    end
                    if (tx_state != GDSP_S_IDLE && tx_cnt != 16'h0000) begin
                        tx_cnt <= tx_cnt - 16'h0001;
                    end else begin
                        tx_cnt <= cfg[p].baud_div - 16'h0001;
                        case (tx_state)
                            GDSP_S_IDLE: begin
                                if (tx_pend) begin
                                    tx_pend          <= 1'b0;
                                    tx_shift         <= tx_hold;
                                    serial_tx_out[p] <= 1'b0;
                                    tx_state         <= GDSP_S_START;
                                end
                            end
                            GDSP_S_START, GDSP_S_DATA: begin
                                if (tx_state == GDSP_S_START) begin
                                    tx_bit <= 3'h0;
                                end else begin
                                    tx_bit <= tx_bit + 3'h1;
                                end
                                if (tx_state == GDSP_S_DATA && tx_bit == last_bit) begin
                                    if (cfg[p].parity != GDSP_PAR_NONE) begin
                                        serial_tx_out[p] <= tx_par;
                                        tx_state         <= GDSP_S_PAR;
                                    end else begin
                                        serial_tx_out[p] <= 1'b1;
                                        tx_stop2         <= cfg[p].two_stop;
                                        tx_state         <= GDSP_S_STOP;
                                    end
                                end else begin
                                    serial_tx_out[p] <= tx_shift[0];
                                    tx_shift         <= {1'b0, tx_shift[7:1]};
                                    tx_state         <= GDSP_S_DATA;
                                end
                            end
                            GDSP_S_PAR: begin
                                serial_tx_out[p] <= 1'b1;
                                tx_stop2         <= cfg[p].two_stop;
                                tx_state         <= GDSP_S_STOP;
                            end
                            GDSP_S_STOP: begin
                                tx_stop2 <= 1'b0;
                                if (!tx_stop2) begin
                                    tx_state <= GDSP_S_IDLE;
                                    tx_cnt   <= 16'h0000;
                                end
                            end
                            default: tx_state <= GDSP_S_IDLE;
                        endcase
                    end
                end
            end

            // receiver samples mid-bit after a start edge
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    rx_state   <= GDSP_S_IDLE;
                    rx_cnt     <= 16'h0000;
                    rx_bit     <= 3'h0;
                    rx_shift   <= 8'h00;
                    rx_byte[p] <= 8'h00;
                    rx_done    <= 1'b0;
                    rx_perr    <= 1'b0;
                    rx_ferr    <= 1'b0;
                end else begin
                    rx_done <= 1'b0;
                    rx_perr <= 1'b0;
                    rx_ferr <= 1'b0;
                    if (rx_state == GDSP_S_IDLE) begin
                        if (!rx_pin) begin
                            rx_cnt   <= {1'b0, cfg[p].baud_div[15:1]};
                            rx_state <= GDSP_S_START;
                        end
                    end else if (rx_cnt != 16'h0000) begin
                        rx_cnt <= rx_cnt - 16'h0001;
                    end else begin
                        rx_cnt <= cfg[p].baud_div - 16'h0001;
                        case (rx_state)
                            GDSP_S_START: begin
                                // a start bit gone by mid-bit was a glitch
                                rx_state <= rx_pin ? GDSP_S_IDLE : GDSP_S_DATA;
                                rx_bit   <= 3'h0;
                                rx_shift <= 8'h00;
                            end
                            GDSP_S_DATA: begin
                                rx_shift[rx_bit] <= rx_pin;
                                rx_bit           <= rx_bit + 3'h1;
                                if (rx_bit == last_bit) begin
                                    rx_state <= (cfg[p].parity != GDSP_PAR_NONE) ? GDSP_S_PAR : GDSP_S_STOP;
                                end
                            end
                            GDSP_S_PAR: begin
                                rx_perr  <= rx_pin != rx_par;
                                rx_state <= GDSP_S_STOP;
                            end
                            GDSP_S_STOP: begin
                                rx_ferr    <= !rx_pin;
                                rx_done    <= 1'b1;
                                rx_byte[p] <= rx_shift;
                                rx_state   <= GDSP_S_IDLE;
                            end
                            default: rx_state <= GDSP_S_IDLE;
                        endcase
                    end
                end
            end

            // status lane: a hardware set in the same cycle as a clear wins
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stat[p] <= 5'h00;
                end else begin
                    stat[p][ST_TX_BUSY]   <= tx_pend || wr_tx[p] || tx_state != GDSP_S_IDLE;
                    stat[p][ST_RX_VALID]  <= rx_done || (stat[p][ST_RX_VALID] && !rd_rx[p]);
                    stat[p][ST_PAR_ERR]   <= rx_perr || (stat[p][ST_PAR_ERR] && !w1c[p][ST_PAR_ERR]);
                    stat[p][ST_FRAME_ERR] <= rx_ferr || (stat[p][ST_FRAME_ERR] && !w1c[p][ST_FRAME_ERR]);
                    stat[p][ST_TX_REJECT] <= tx_reject[p] || (stat[p][ST_TX_REJECT] && !w1c[p][ST_TX_REJECT]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // second tick: free-running count, snapped to the navigation second start

    logic [SEC_W-1:0] sec_cnt;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sec_cnt               <= '0;
            tick_aligned          <= 1'b0;
            second_tick_pulse_out <= 1'b0;
            tick_accurate_out     <= 1'b0;
        end else begin
            if (nav_second_start_in || sec_cnt == SEC_W'(SECOND_CYCLES - 1)) begin
                sec_cnt <= '0;
            end else begin
                sec_cnt <= sec_cnt + 1'b1;
            end
            if (nav_second_start_in) begin
                tick_aligned <= 1'b1;
            end else if (!nav_fix_valid_in) begin
                tick_aligned <= 1'b0;
            end
            // a realignment starts a fresh full-width pulse; only its rising edge carries time
            second_tick_pulse_out <= ctrl[CTRL_TICK_BIT] &&
                                     (nav_second_start_in || sec_cnt == SEC_W'(SECOND_CYCLES - 1) ||
                                      (second_tick_pulse_out && sec_cnt < SEC_W'(TICK_WIDTH_CYC - 1)));
            tick_accurate_out     <= nav_fix_valid_in && tick_aligned;
        end
    end

endmodule // gdsp_top

// *** hdl/gdsp_pkg.sv ***
// constants, register map and types of the dual serial port and second tick block
package gdsp_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TICK_WIDTH_US   = 10;
    localparam int unsigned TICK_WIDTH_CYC  = (CLK_HZ / 1_000_000) * TICK_WIDTH_US;
    localparam int unsigned SECOND_CYC      = CLK_HZ;
    localparam int unsigned BAUD_BINARY     = 9600;
    localparam int unsigned BAUD_TEXT       = 4800;
    localparam logic [15:0] DIV_BINARY      = 16'((CLK_HZ + BAUD_BINARY / 2) / BAUD_BINARY);
    localparam logic [15:0] DIV_TEXT        = 16'((CLK_HZ + BAUD_TEXT / 2) / BAUD_TEXT);

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CFG0   = 8'h04;
    localparam logic [7:0] ADDR_CFG1   = 8'h08;
    localparam logic [7:0] ADDR_DATA0  = 8'h0C;
    localparam logic [7:0] ADDR_DATA1  = 8'h10;
    localparam logic [7:0] ADDR_STAT   = 8'h14;
    localparam logic [7:0] ADDR_NVCMD  = 8'h18;

    // control fields
    localparam int CTRL_PROTO_BIT = 0;   // primary port: 0 binary, 1 ascii
    localparam int CTRL_TRACK_BIT = 1;
    localparam int CTRL_TICK_BIT  = 2;
    localparam logic [2:0] CTRL_RESET = 3'h6;

    // status fields, one 8-bit lane per port, then tick state
    localparam int ST_TX_BUSY   = 0;
    localparam int ST_RX_VALID  = 1;
    localparam int ST_PAR_ERR   = 2;
    localparam int ST_FRAME_ERR = 3;
    localparam int ST_TX_REJECT = 4;
    localparam int ST_LANE      = 8;
    localparam int ST_FIX_BIT   = 16;
    localparam int ST_ALIGN_BIT = 17;
    localparam logic [4:0] ST_W1C_MASK = 5'h1C;

    // nonvolatile command bits and marker
    localparam int NV_SAVE_BIT    = 0;
    localparam int NV_RESTORE_BIT = 1;
    localparam logic [15:0] NV_MARKER = 16'hA5C3;

    localparam logic [7:0] CHAR_LF = 8'h0A;
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_LO = 8'h20;
    localparam logic [7:0] CHAR_HI = 8'h7E;

    typedef enum logic [1:0] {
        GDSP_PAR_NONE,
        GDSP_PAR_ODD,
        GDSP_PAR_EVEN
    } gdsp_parity_t;

    // port framing: cfg word bits [15:0] divisor, [16] eight data bits, [18:17] parity, [19] two stops
    typedef struct packed {
        logic         two_stop;
        gdsp_parity_t parity;
        logic         eight_bits;
        logic [15:0]  baud_div;
    } gdsp_cfg_t;

    localparam gdsp_cfg_t CFG_BINARY = '{two_stop: 1'b0, parity: GDSP_PAR_ODD,  eight_bits: 1'b1,
                                         baud_div: DIV_BINARY};
    localparam gdsp_cfg_t CFG_TEXT   = '{two_stop: 1'b0, parity: GDSP_PAR_NONE, eight_bits: 1'b1,
                                         baud_div: DIV_TEXT};

    typedef enum logic [2:0] {
        GDSP_S_IDLE,
        GDSP_S_START,
        GDSP_S_DATA,
        GDSP_S_PAR,
        GDSP_S_STOP
    } gdsp_state_t;
endpackage

// *** test/gdsp_properties.sv ***
// concurrent checks on the ports of the dual serial port block
`timescale 1ns/1ps
module gdsp_properties
    import gdsp_pkg::*;
(
    input wire logic       clock_in, rst_n_in, psel_in, penable_in, pready_out, pslverr_out,
    input wire logic [7:0] paddr_in,
    input wire logic [1:0] serial_tx_out,
    input wire logic       nav_second_start_in, nav_fix_valid_in,
    input wire logic       second_tick_pulse_out, tick_accurate_out, track_enable_out
);
    logic [15:0] high_cnt;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // counts sampled high cycles, so the check sees the full width at the fall
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) high_cnt <= 16'h0;
        else high_cnt <= second_tick_pulse_out ? high_cnt + 16'h1 : 16'h0;
    end
    a_pready_pulse: assert property (pready_out |=> !pready_out) else $error("pready too long");
    a_one_wait: assert property ((psel_in && !penable_in) ##1 (psel_in && penable_in) |=> pready_out)
        else $error("pready late");
    a_unmapped_err: assert property (pready_out |-> pslverr_out == (paddr_in > ADDR_NVCMD || paddr_in[1:0] != 2'b00))
        else $error("slave error wrong");
    a_tick_width: assert property ($fell(second_tick_pulse_out) |-> high_cnt == TICK_WIDTH_CYC)
        else $error("tick width wrong");
    a_tick_align: assert property (nav_second_start_in && !second_tick_pulse_out |=> $rose(second_tick_pulse_out))
        else $error("tick not aligned");
    a_fix_gate: assert property (!nav_fix_valid_in |=> !tick_accurate_out)
        else $error("accurate without fix");
    a_track_boot: assert property ($rose(rst_n_in) |-> track_enable_out)
        else $error("tracking off at start");
    a_start_len: assert property ($fell(serial_tx_out[0]) |-> !serial_tx_out[0] [*8])
        else $error("short low bit");
endmodule // gdsp_properties

// *** test/gdsp_host_uart.sv ***
// host uart model facing one serial port of the block
`timescale 1ns/1ps
module gdsp_host_uart #(
    parameter int DIV = 16,
    parameter bit PAR = 1'b1
) (
    input  wire logic clock_in,
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] got;
    logic       ok;
    initial line_out = 1'b1;
    // mid-bit sampling of the start bit clears ok on a glitch, but the whole frame is still read
    always begin
        @(negedge line_in);
        repeat (DIV / 2) @(posedge clock_in);
        ok = !line_in;
        for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clock_in);
            got[i] = line_in;
        end
        if (PAR) begin
            repeat (DIV) @(posedge clock_in);
            ok = ok & (^got ^ line_in);
        end
        repeat (DIV) @(posedge clock_in);
        ok = ok & line_in;
    end
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = PAR ? {1'b1, ~^b, b, 1'b0} : {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clock_in);
            line_out <= f[i];
            repeat (DIV - 1) @(posedge clock_in);
        end
    endtask
endmodule // gdsp_host_uart

// *** test/gdsp_top_test.sv ***
// self-checking bench for the dual serial port and second tick block
`timescale 1ns/1ps
module gdsp_top_test
    import gdsp_pkg::*;
;
    logic        clock_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, ev;
    logic        nav_second_start_in, nav_fix_valid_in, second_tick_pulse_out, tick_accurate_out;
    logic        track_enable_out;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rdv;
    logic [1:0]  serial_tx_out;
    wire  [1:0]  serial_rx_in;
    int          n_fail, check_count;
    gdsp_top #(.SECOND_CYCLES(5000)) uut (.*);
    gdsp_host_uart #(.PAR(1)) h0 (.clock_in, .line_in(serial_tx_out[0]), .line_out(serial_rx_in[0]));
    gdsp_host_uart #(.PAR(0)) h1 (.clock_in, .line_in(serial_tx_out[1]), .line_out(serial_rx_in[1]));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
        @(posedge clock_in);
        penable_in <= 1'b1;
        // only the watchdog ends a wait for the answer
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rdv = prdata_out;
        ev = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rdv & m);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        #500_000;
        n_fail++;
        finish_test();
    end
    initial begin
        {rst_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {nav_second_start_in, nav_fix_valid_in, n_fail, check_count} = '0;
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        chk("track", 32'h1, {31'h0, track_enable_out});
        {nav_fix_valid_in, nav_second_start_in} <= 2'b11;
        @(posedge clock_in);
        nav_second_start_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk("tick", 32'h1, {31'h0, second_tick_pulse_out});
        chk("accurate", 32'h1, {31'h0, tick_accurate_out});
        nav_fix_valid_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk("accurate", 32'h0, {31'h0, tick_accurate_out});
        $display("test tick ended");
        rd(ADDR_CTRL, {29'h0, CTRL_RESET}, 32'hFFFFFFFF);
        rd(ADDR_CFG0, {12'h0, CFG_BINARY}, 32'hFFFFFFFF);
        rd(ADDR_CFG1, {12'h0, CFG_TEXT}, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        chk("slverr", 32'h1, {31'h0, ev});
        apb(1'b1, ADDR_CTRL, 32'h7);
        rd(ADDR_CFG0, {12'h0, CFG_TEXT}, 32'hFFFFFFFF);
        apb(1'b1, ADDR_CTRL, 32'h6);
        rd(ADDR_CFG0, {12'h0, CFG_BINARY}, 32'hFFFFFFFF);
        $display("test defaults ended");
        apb(1'b1, ADDR_CFG0, 32'h00030010);
        apb(1'b1, ADDR_CFG1, 32'h00010010);
        apb(1'b1, ADDR_DATA0, 32'hC5);
        repeat (200) @(posedge clock_in);
        chk("host0 byte", 32'hC5, {24'h0, h0.got});
        chk("host0 frame", 32'h1, {31'h0, h0.ok});
        h0.send(8'h3A);
        rd(ADDR_DATA0, 32'h3A, 32'hFFFFFFFF);
        apb(1'b1, ADDR_DATA1, 32'h01);
        rd(ADDR_STAT, 32'h1000, 32'h1000);
        apb(1'b1, ADDR_DATA1, 32'h41);
        repeat (200) @(posedge clock_in);
        chk("host1 byte", 32'h41, {24'h0, h1.got});
        chk("host1 frame", 32'h1, {31'h0, h1.ok});
        $display("test serial ended");
        apb(1'b1, ADDR_NVCMD, 32'h1);
        apb(1'b1, ADDR_CFG1, {12'h0, CFG_TEXT});
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        rd(ADDR_CFG1, 32'h00010010, 32'hFFFFFFFF);
        rd(ADDR_NVCMD, 32'h1, 32'hFFFFFFFF);
        $display("test storage ended");
        finish_test();
    end
endmodule // gdsp_top_test
bind gdsp_top gdsp_properties chk_i (.*);
